// file: rtl/nsc_node_switch_config_regs.sv
// configuration register bank and direction lookup of one node's system switch
//
// Contract
// - requester reads every register and writes the writable ones by number; bank answers reads with contents
// - identification word carries captured boot pins, switch revision and version
// - description word reports link count and processor counts, read only
// - configuration bit 31 set blocks writes to the switch control registers
// - configuration bit 8 set makes the pll settings register ignore writes
// - configuration bit 0 selects two-byte headers at zero, one-byte at one
// - node identifier is a writable 16-bit field cleared at reset
// - every accepted pll settings write resets the tile unless bit 31 set
// - pll write with bit 31 set applies settings without chip reset
// - pll write with bit 30 set skips waiting for pll relock
// - pll settings bit 29 puts the pll into bypass
// - pll settings bit 28 forces boot from the jtag port
// - pll settings hold output divider, feedback ratio and input divider fields
// - switch clock divider holds a 16-bit ratio reset to zero
// - reference clock divider holds a 16-bit ratio reset to three
// - usercode word shows otp usercode high and metal id code low
// - mismatching packet routes by direction of most significant differing id bit
// - lower direction word holds nibbles for dimensions 0 to 7
// - upper direction word holds nibbles for dimensions 8 to 15
`timescale 1ns/10ps
`default_nettype none

module nsc_node_switch_config_regs #(
    parameter logic [7:0]  SWITCH_REVISION = 8'h01,   // arbitrary value
    parameter logic [7:0]  SWITCH_VERSION  = 8'h02,   // arbitrary value
    parameter logic [7:0]  LINK_COUNT      = 8'h08,
    parameter logic [7:0]  SWITCH_PROCS    = 8'h02,
    parameter logic [7:0]  DEVICE_PROCS    = 8'h02,
    parameter logic [31:0] JTAG_ID_CODE    = 32'h1234_5001, // arbitrary value
    parameter logic [17:0] METAL_ID_CODE   = 18'h00001,     // arbitrary value
    parameter logic [31:0] PLL_RESET       = 32'h0000_0000
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [7:0]       boot_control_pins,
    input  wire logic [13:0]      otp_usercode,
    input  wire nsc_pkg::nsc_req_t cfg_req,
    output nsc_pkg::nsc_rsp_t     cfg_rsp,
    output logic                  one_byte_headers,
    output logic [15:0]           node_id,
    output nsc_pkg::nsc_pll_t     pll_cfg,
    output logic                  pll_update,
    output logic                  tile_reset,
    output logic                  pll_skip_relock,
    output logic [15:0]           switch_clock_ratio,
    output logic [15:0]           reference_clock_ratio,
    input  wire logic             route_valid,
    input  wire logic [15:0]      route_dest_id,
    output logic                  route_done,
    output logic                  route_local,
    output logic [3:0]            route_direction
);

    // ------------------------------------------------------------------
    // stored state
    // ------------------------------------------------------------------
    logic [7:0]  boot_pins_r;
    logic        boot_taken_r;
    logic        cfg_write_lock_r;
    logic        cfg_pll_lock_r;
    logic        cfg_header_mode_r;
    logic [15:0] node_id_r;
    logic [31:0] pll_r;
    logic [15:0] switch_div_r;
    logic [15:0] ref_div_r;
    logic [31:0] dirs_low_r;
    logic [31:0] dirs_high_r;
    logic        rsp_valid_r;
    logic        rsp_error_r;
    logic [31:0] rsp_rdata_r;
    logic        pll_update_r;
    logic        tile_reset_r;
    logic        skip_relock_r;
    logic        route_done_r;
    logic        route_local_r;
    logic [3:0]  route_dir_r;

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    wire logic is_read   = cfg_req.valid & ~cfg_req.write;
    wire logic is_write  = cfg_req.valid & cfg_req.write;

    wire logic hit_id    = (cfg_req.number == nsc_pkg::REG_DEVICE_IDENTIFICATION);
    wire logic hit_desc  = (cfg_req.number == nsc_pkg::REG_SWITCH_DESCRIPTION);
    wire logic hit_cfg   = (cfg_req.number == nsc_pkg::REG_SWITCH_CONFIGURATION);
    wire logic hit_node  = (cfg_req.number == nsc_pkg::REG_NODE_IDENTIFIER);
    wire logic hit_pll   = (cfg_req.number == nsc_pkg::REG_PLL_SETTINGS);
    wire logic hit_sdiv  = (cfg_req.number == nsc_pkg::REG_SWITCH_CLOCK_DIVIDER);
    wire logic hit_rdiv  = (cfg_req.number == nsc_pkg::REG_REFERENCE_CLOCK_DIVIDER);
    wire logic hit_jtag  = (cfg_req.number == nsc_pkg::REG_JTAG_DEVICE_ID);
    wire logic hit_user  = (cfg_req.number == nsc_pkg::REG_USER_CODE);
    wire logic hit_dlow  = (cfg_req.number == nsc_pkg::REG_ROUTE_DIRECTIONS_LOW);
    wire logic hit_dhigh = (cfg_req.number == nsc_pkg::REG_ROUTE_DIRECTIONS_HIGH);

    wire logic hit_any = hit_id | hit_desc | hit_cfg | hit_node | hit_pll | hit_sdiv
                       | hit_rdiv | hit_jtag | hit_user | hit_dlow | hit_dhigh;

    // the configuration word itself stays writable so the lock can be lifted
    wire logic ctl_open = ~cfg_write_lock_r;
    wire logic wr_cfg   = is_write & hit_cfg;
    wire logic wr_node  = is_write & hit_node  & ctl_open;
    wire logic wr_sdiv  = is_write & hit_sdiv  & ctl_open;
    wire logic wr_rdiv  = is_write & hit_rdiv  & ctl_open;
    wire logic wr_dlow  = is_write & hit_dlow  & ctl_open;
    wire logic wr_dhigh = is_write & hit_dhigh & ctl_open;
    wire logic wr_pll   = is_write & hit_pll & ctl_open & ~cfg_pll_lock_r;

    // ------------------------------------------------------------------
    // read words
    // ------------------------------------------------------------------
    // reserved bits are plain zeros in every word except pll settings bits 22 and 21, which read back as written
    wire logic [31:0] word_id   = (32'(boot_pins_r) << nsc_pkg::ID_BOOT_LSB)
                                | (32'(SWITCH_REVISION) << nsc_pkg::ID_REV_LSB)
                                | 32'(SWITCH_VERSION);
    wire logic [31:0] word_desc = (32'(LINK_COUNT) << nsc_pkg::ID_BOOT_LSB)
                                | (32'(SWITCH_PROCS) << nsc_pkg::ID_REV_LSB)
                                | 32'(DEVICE_PROCS);
    wire logic [31:0] word_cfg  = {cfg_write_lock_r, 22'h000000, cfg_pll_lock_r,
                                   7'h00, cfg_header_mode_r};
    wire logic [31:0] word_node = {16'h0000, node_id_r};
    wire logic [31:0] word_sdiv = {16'h0000, switch_div_r};
    wire logic [31:0] word_rdiv = {16'h0000, ref_div_r};
    wire logic [31:0] word_user = (32'(otp_usercode) << nsc_pkg::USER_OTP_LSB)
                                | 32'(METAL_ID_CODE);

    wire logic [31:0] read_word =
          hit_id    ? word_id
        : hit_desc  ? word_desc
        : hit_cfg   ? word_cfg
        : hit_node  ? word_node
        : hit_pll   ? pll_r
        : hit_sdiv  ? word_sdiv
        : hit_rdiv  ? word_rdiv
        : hit_jtag  ? JTAG_ID_CODE
        : hit_user  ? word_user
        : hit_dlow  ? dirs_low_r
        : hit_dhigh ? dirs_high_r
        : 32'h0000_0000;

    // ------------------------------------------------------------------
    // routing lookup
    // ------------------------------------------------------------------
    wire logic [15:0] id_diff = route_dest_id ^ node_id_r;
    wire logic [63:0] dir_table = {dirs_high_r, dirs_low_r};

    // lookups see id and tables as they stood before the edge
    // per-dimension one-hot of the most significant differing bit
    logic [15:0] top_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_dim
            if (gi == 15) begin : g_top
                assign top_hit[gi] = id_diff[gi];
            end else begin : g_lower
                assign top_hit[gi] = id_diff[gi] & ~(|id_diff[15:gi+1]);
            end
        end
    endgenerate

    logic [3:0] dir_pick;
    always_comb begin
        dir_pick = 4'h0;
        for (int d = 0; d < 16; d++) begin
            if (top_hit[d]) begin
                dir_pick = dir_table[d*4 +: 4];
            end
        end
    end

    wire logic id_match = (id_diff == 16'h0000);

    // ------------------------------------------------------------------
    // boot pin capture, one cycle after reset release
    // every nrst counts as power-on here, so a mid-run reset retakes the pins
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            boot_taken_r <= 1'b0;
            boot_pins_r  <= 8'h00;
        end else if (!boot_taken_r) begin
            boot_taken_r <= 1'b1;
            boot_pins_r  <= boot_control_pins;
        end
    end

    // ------------------------------------------------------------------
    // switch configuration and node identifier
    // header mode is only reported onward; packets are not reframed here
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg_write_lock_r  <= 1'b0;
            cfg_pll_lock_r    <= 1'b0;
            cfg_header_mode_r <= 1'b0;
        end else if (wr_cfg) begin
            cfg_write_lock_r  <= cfg_req.wdata[nsc_pkg::CFG_WRITE_LOCK_BIT];
            cfg_pll_lock_r    <= cfg_req.wdata[nsc_pkg::CFG_PLL_LOCK_BIT];
            cfg_header_mode_r <= cfg_req.wdata[nsc_pkg::CFG_HEADER_MODE_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            node_id_r <= nsc_pkg::NODE_ID_RESET;
        end else if (wr_node) begin
            node_id_r <= cfg_req.wdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // pll settings and its side effects
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pll_r <= PLL_RESET & nsc_pkg::PLL_WRITE_MASK;
        end else if (wr_pll) begin
            pll_r <= cfg_req.wdata & nsc_pkg::PLL_WRITE_MASK;
        end
    end

    // pulses come from the written word, not the stored one, so they match it
    wire logic pll_spare_chip = cfg_req.wdata[nsc_pkg::PLL_NO_RESET_BIT];
    wire logic pll_no_relock  = cfg_req.wdata[nsc_pkg::PLL_NO_RELOCK_BIT];

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pll_update_r <= 1'b0;
            tile_reset_r <= 1'b0;
        end else begin
            pll_update_r <= wr_pll;
            tile_reset_r <= wr_pll & ~pll_spare_chip;
        end
    end

    // a level, not a pulse: the relock sequencer reads it after the update
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            skip_relock_r <= 1'b0;
        end else if (wr_pll) begin
            skip_relock_r <= pll_no_relock;
        end
    end

    // ------------------------------------------------------------------
    // clock dividers and direction tables
    // ratios pass on raw; a zero divider is for the clock logic to handle
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            switch_div_r <= nsc_pkg::SWITCH_DIV_RESET;
        end else if (wr_sdiv) begin
            switch_div_r <= cfg_req.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ref_div_r <= nsc_pkg::REF_DIV_RESET;
        end else if (wr_rdiv) begin
            ref_div_r <= cfg_req.wdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dirs_low_r  <= nsc_pkg::DIRS_RESET;
            dirs_high_r <= nsc_pkg::DIRS_RESET;
        end else begin
            if (wr_dlow) begin
                dirs_low_r <= cfg_req.wdata;
            end
            if (wr_dhigh) begin
                dirs_high_r <= cfg_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // answer: one cycle after the request, reads carry data
    // unmapped numbers read as zero but flag an error, so a wrong number is not taken for a zero register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rsp_valid_r <= 1'b0;
            rsp_error_r <= 1'b0;
            rsp_rdata_r <= 32'h0000_0000;
        end else begin
            rsp_valid_r <= cfg_req.valid;
            rsp_error_r <= cfg_req.valid & ~hit_any;
            rsp_rdata_r <= is_read ? read_word : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // route answer, registered one cycle after the lookup request
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            route_done_r  <= 1'b0;
            route_local_r <= 1'b0;
            route_dir_r   <= 4'h0;
        end else begin
            route_done_r <= route_valid;
            if (route_valid) begin
                route_local_r <= id_match;
                route_dir_r   <= id_match ? 4'h0 : dir_pick;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign cfg_rsp.valid = rsp_valid_r;
    assign cfg_rsp.error = rsp_error_r;
    assign cfg_rsp.rdata = rsp_rdata_r;

    assign one_byte_headers      = cfg_header_mode_r;
    assign node_id               = node_id_r;
    assign pll_cfg.bypass        = pll_r[nsc_pkg::PLL_BYPASS_BIT];
    assign pll_cfg.jtag_boot     = pll_r[nsc_pkg::PLL_JTAG_BOOT_BIT];
    assign pll_cfg.output_divider = pll_r[nsc_pkg::PLL_OD_MSB:nsc_pkg::PLL_OD_LSB];
    assign pll_cfg.feedback_mult = pll_r[nsc_pkg::PLL_F_MSB:nsc_pkg::PLL_F_LSB];
    assign pll_cfg.input_divider = pll_r[nsc_pkg::PLL_R_MSB:nsc_pkg::PLL_R_LSB];
    assign pll_update            = pll_update_r;
    assign tile_reset            = tile_reset_r;
    assign pll_skip_relock       = skip_relock_r;
    assign switch_clock_ratio    = switch_div_r;
    assign reference_clock_ratio = ref_div_r;
    assign route_done            = route_done_r;
    assign route_local           = route_local_r;
    assign route_direction       = route_dir_r;

endmodule // nsc_node_switch_config_regs

`default_nettype wire

// file: rtl/nsc_pkg.sv
// shared constants and carrier types for the node switch configuration bank
package nsc_pkg;

    // register numbers
    localparam logic [7:0] REG_DEVICE_IDENTIFICATION  = 8'h00;
    localparam logic [7:0] REG_SWITCH_DESCRIPTION     = 8'h01;
    localparam logic [7:0] REG_SWITCH_CONFIGURATION   = 8'h04;
    localparam logic [7:0] REG_NODE_IDENTIFIER        = 8'h05;
    localparam logic [7:0] REG_PLL_SETTINGS           = 8'h06;
    localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER   = 8'h07;
    localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
    localparam logic [7:0] REG_JTAG_DEVICE_ID         = 8'h09;
    localparam logic [7:0] REG_USER_CODE              = 8'h0a;
    localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW   = 8'h0c;
    localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH  = 8'h0d;

    // switch configuration fields
    localparam int unsigned CFG_WRITE_LOCK_BIT  = 31;
    localparam int unsigned CFG_PLL_LOCK_BIT    = 8;
    localparam int unsigned CFG_HEADER_MODE_BIT = 0;

    // pll settings fields
    localparam int unsigned PLL_NO_RESET_BIT   = 31;
    localparam int unsigned PLL_NO_RELOCK_BIT  = 30;
    localparam int unsigned PLL_BYPASS_BIT     = 29;
    localparam int unsigned PLL_JTAG_BOOT_BIT  = 28;
    localparam int unsigned PLL_OD_MSB         = 25;
    localparam int unsigned PLL_OD_LSB         = 23;
    localparam int unsigned PLL_F_MSB          = 20;
    localparam int unsigned PLL_F_LSB          = 8;
    localparam int unsigned PLL_R_MSB          = 6;
    localparam int unsigned PLL_R_LSB          = 0;
    localparam logic [31:0] PLL_WRITE_MASK     = 32'hf3ff_ff7f;

    // identification and description layout
    localparam int unsigned ID_BOOT_LSB = 16;
    localparam int unsigned ID_REV_LSB  = 8;
    localparam int unsigned USER_OTP_LSB = 18;

    // reset values
    localparam logic [15:0] NODE_ID_RESET    = 16'h0000;
    localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
    localparam logic [15:0] REF_DIV_RESET    = 16'h0003;
    localparam logic [31:0] DIRS_RESET       = 32'h0000_0000;

    // routing
    localparam int unsigned DIR_W    = 4;
    localparam int unsigned NODE_ID_W = 16;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  number;
        logic [31:0] wdata;
    } nsc_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] rdata;
    } nsc_rsp_t;

    typedef struct packed {
        logic        bypass;
        logic        jtag_boot;
        logic [2:0]  output_divider;
        logic [12:0] feedback_mult;
        logic [6:0]  input_divider;
    } nsc_pll_t;

endpackage

// file: verif/nsc_cfg_requester.sv
// requester model issuing configuration reads and writes by register number
`timescale 1ns/10ps
`default_nettype none

module nsc_cfg_requester (
    input  wire logic              core_clk,
    output var nsc_pkg::nsc_req_t  cfg_req,
    input  wire nsc_pkg::nsc_rsp_t cfg_rsp
);
    initial cfg_req = '0;

    // one request per call, driven on falling edges; a gap cycle always follows
    task automatic xfer(input logic wr, input logic [7:0] num, input logic [31:0] wd,
                        output nsc_pkg::nsc_rsp_t rsp);
        @(negedge core_clk);
        cfg_req = '{valid: 1'b1, write: wr, number: num, wdata: wd};
        @(negedge core_clk);
        rsp = cfg_rsp;
        // released number and data lines must not keep their last value; write keeps it
        cfg_req = '{valid: 1'b0, write: wr, number: ~num, wdata: ~wd};
    endtask
endmodule // nsc_cfg_requester

`default_nettype wire

// file: verif/nsc_monitor.sv
// concurrent checks on the ports of the node switch configuration bank
`timescale 1ns/10ps
`default_nettype none

module nsc_monitor (
    input wire logic              core_clk,
    input wire logic              nrst,
    input wire nsc_pkg::nsc_req_t cfg_req,
    input wire nsc_pkg::nsc_rsp_t cfg_rsp,
    input wire logic [15:0]       node_id,
    input wire logic              pll_update,
    input wire logic              tile_reset,
    input wire logic              route_valid,
    input wire logic              route_done,
    input wire logic              route_local,
    input wire logic [3:0]        route_direction
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    wire logic wr_any  = cfg_req.valid && cfg_req.write;
    wire logic wr_pll  = wr_any && cfg_req.number == 8'h06;
    wire logic wr_node = wr_any && cfg_req.number == 8'h05;

    chk_rsp_follows_req: assert property (cfg_req.valid |=> cfg_rsp.valid)
        else $error("no response one cycle after request");
    chk_rsp_no_extra: assert property (!cfg_req.valid |=> !cfg_rsp.valid)
        else $error("response without request");
    chk_unmapped_err: assert property (cfg_req.valid && cfg_req.number == 8'h02 |=>
        cfg_rsp.error && cfg_rsp.rdata == 32'h0) else $error("unmapped number not flagged");
    chk_tile_reset_cause: assert property (tile_reset |->
        pll_update && $past(wr_pll && !cfg_req.wdata[31])) else $error("tile reset without cause");
    chk_no_chip_reset: assert property (wr_pll && cfg_req.wdata[31] |=> !tile_reset)
        else $error("tile reset despite suppress bit");
    chk_update_cause: assert property (pll_update |-> $past(wr_pll))
        else $error("pll update without pll write");
    // after a reset the first compare still sees the pre-reset value
    chk_node_id_src: assert property (!$stable(node_id) && $past(nrst) |-> $past(wr_node))
        else $error("node id changed without write");
    chk_route_done: assert property (route_valid |=> route_done)
        else $error("lookup not answered");
    chk_local_dir: assert property (route_done && route_local |-> route_direction == 4'h0)
        else $error("local packet given a direction");

    cover property (wr_pll ##1 tile_reset);
    cover property (route_done && route_local);
    cover property (cfg_rsp.valid && cfg_rsp.error);
endmodule // nsc_monitor

`default_nettype wire

// file: verif/test_node_switch_config_regs.sv
// self-checking bench for the node switch configuration bank
`timescale 1ns/10ps
`default_nettype none

module test_node_switch_config_regs;
    localparam logic [7:0]  REV   = 8'h5a;        // arbitrary value
    localparam logic [7:0]  VER   = 8'h3c;        // arbitrary value
    localparam logic [31:0] JTAG  = 32'h0bad_0001; // arbitrary value
    localparam logic [17:0] METAL = 18'h2a5a5;    // arbitrary value

    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic [7:0]        boot_control_pins = 8'hc3;
    logic [13:0]       otp_usercode = 14'h2b1d;
    logic              route_valid = 1'b0;
    logic [15:0]       route_dest_id = 16'h0000;
    nsc_pkg::nsc_req_t cfg_req;
    nsc_pkg::nsc_rsp_t cfg_rsp;
    nsc_pkg::nsc_pll_t pll_cfg;
    logic              one_byte_headers, pll_update, tile_reset, pll_skip_relock;
    logic              route_done, route_local;
    logic [15:0]       node_id, switch_clock_ratio, reference_clock_ratio;
    logic [3:0]        route_direction;
    int                n_errors = 0;
    int                checks_done = 0;
    int                n_tiles = 0;
    int                n_updates = 0;

    always #10 core_clk = ~core_clk;

    // pulses counted mid-cycle, where they stand settled
    always @(negedge core_clk) begin
        if (tile_reset === 1'b1)
            n_tiles <= n_tiles + 1;
        if (pll_update === 1'b1)
            n_updates <= n_updates + 1;
    end

    nsc_node_switch_config_regs #(.SWITCH_REVISION(REV), .SWITCH_VERSION(VER),
        .JTAG_ID_CODE(JTAG), .METAL_ID_CODE(METAL)) uut (
        .core_clk(core_clk), .nrst(nrst), .boot_control_pins(boot_control_pins),
        .otp_usercode(otp_usercode), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .one_byte_headers(one_byte_headers), .node_id(node_id), .pll_cfg(pll_cfg),
        .pll_update(pll_update), .tile_reset(tile_reset), .pll_skip_relock(pll_skip_relock),
        .switch_clock_ratio(switch_clock_ratio), .reference_clock_ratio(reference_clock_ratio),
        .route_valid(route_valid), .route_dest_id(route_dest_id), .route_done(route_done),
        .route_local(route_local), .route_direction(route_direction));

    nsc_cfg_requester u_req (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] num, input logic [31:0] d);
        nsc_pkg::nsc_rsp_t r;
        u_req.xfer(1'b1, num, d, r);
        check("write response", {30'h0, r.valid, r.error}, 32'h2);
    endtask

    task automatic rd(input logic [7:0] num, input logic [31:0] exp);
        nsc_pkg::nsc_rsp_t r;
        u_req.xfer(1'b0, num, 32'h0, r);
        check("read response", {30'h0, r.valid, r.error}, 32'h2);
        check($sformatf("register %h", num), r.rdata, exp);
    endtask

    task automatic route(input logic [15:0] dest, input logic loc, input logic [3:0] dir);
        @(negedge core_clk);
        route_valid = 1'b1;
        route_dest_id = dest;
        @(negedge core_clk);
        route_valid = 1'b0;
        route_dest_id = ~dest;
        check("route", {26'h0, route_done, route_local, route_direction}, {26'h0, 1'b1, loc, dir});
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #100us;
        n_errors++;
        end_sim();
    end

    initial begin
        nsc_pkg::nsc_rsp_t r;
        static logic [7:0]  bad [3] = '{8'h02, 8'h0b, 8'hff};
        static logic [31:0] pw = {4'h8, 2'h0, 3'h5, 2'h0, 13'h0abc, 1'b0, 7'h21};
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        boot_control_pins = 8'h00; // pins already captured
        rd(8'h00, {8'h00, 8'hc3, REV, VER});
        rd(8'h01, 32'h0008_0202);
        rd(8'h04, 32'h0);
        rd(8'h05, 32'h0);
        rd(8'h06, 32'h0);
        rd(8'h07, 32'h0);
        rd(8'h08, 32'h3);
        rd(8'h09, JTAG);
        rd(8'h0a, {14'h2b1d, METAL});
        rd(8'h0c, 32'h0);
        rd(8'h0d, 32'h0);
        wr(8'h04, 32'h7fff_fefe);
        rd(8'h04, 32'h0);
        wr(8'h04, 32'h0000_0001);
        rd(8'h04, 32'h1);
        check("one byte headers", {31'h0, one_byte_headers}, 32'h1);
        wr(8'h05, 32'hffff_ffff);
        rd(8'h05, 32'h0000_ffff);
        check("node id", {16'h0, node_id}, 32'hffff);
        wr(8'h07, 32'hffff_1234);
        rd(8'h07, 32'h1234);
        check("switch ratio", {16'h0, switch_clock_ratio}, 32'h1234);
        wr(8'h08, 32'hffff_0009);
        check("reference ratio", {16'h0, reference_clock_ratio}, 32'h9);
        wr(8'h0c, 32'h7654_3210);
        rd(8'h0c, 32'h7654_3210);
        wr(8'h0d, 32'hfedc_ba98);
        rd(8'h0d, 32'hfedc_ba98);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, {8'h00, 8'hc3, REV, VER});
        // relock skip only set here because the step is small
        wr(8'h06, 32'h7fff_ffff);
        rd(8'h06, 32'h73ff_ff7f);
        check("pll fields", 32'(pll_cfg), 32'h01ff_ffff);
        check("skip relock", {31'h0, pll_skip_relock}, 32'h1);
        check("tile resets", n_tiles, 1);
        wr(8'h06, pw);
        rd(8'h06, pw);
        check("pll fields", 32'(pll_cfg), {7'h00, 2'h0, 3'h5, 13'h0abc, 7'h21});
        check("skip relock", {31'h0, pll_skip_relock}, 32'h0);
        check("tile resets", n_tiles, 1);
        check("pll updates", n_updates, 2);
        wr(8'h04, 32'h0000_0100);
        wr(8'h06, 32'h0);
        rd(8'h06, pw);
        check("pll updates", n_updates, 2);
        wr(8'h04, 32'h8000_0000);
        wr(8'h05, 32'h0);
        wr(8'h07, 32'h0);
        wr(8'h0c, 32'h0);
        wr(8'h06, 32'h0);
        rd(8'h05, 32'h0000_ffff);
        rd(8'h07, 32'h1234);
        rd(8'h0c, 32'h7654_3210);
        check("pll updates", n_updates, 2);
        wr(8'h04, 32'h0);
        wr(8'h05, 32'h0000_00a5);
        route(16'h00a5, 1'b1, 4'h0);
        for (int n = 0; n < 16; n++) begin
            // lower bits differ too, so only the top mismatch may decide
            route(16'h00a5 ^ (16'h1 << n) ^ ((16'h1 << n) - 16'h1), 1'b0, n[3:0]);
        end
        foreach (bad[i]) begin
            u_req.xfer(1'b1, bad[i], 32'hffff_ffff, r);
            check("unmapped", {31'h0, r.error}, 32'h1);
        end
        @(negedge core_clk);
        nrst = 1'b0;
        @(negedge core_clk);
        nrst = 1'b1;
        rd(8'h05, 32'h0);
        rd(8'h08, 32'h3);
        rd(8'h00, {8'h00, 8'h00, REV, VER});
        end_sim();
    end
endmodule // test_node_switch_config_regs

bind nsc_node_switch_config_regs nsc_monitor u_mon (
    .core_clk(core_clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .node_id(node_id), .pll_update(pll_update), .tile_reset(tile_reset),
    .route_valid(route_valid), .route_done(route_done), .route_local(route_local),
    .route_direction(route_direction));

`default_nettype wire
